// file: shared/wwdt_pkg.sv
// Constants shared by the windowed watchdog timer.
package wwdt_pkg;
  // Bus clock and nominal low-speed oscillator rate.
  localparam int unsigned PCLK_HZ = 125_000_000;
  localparam int unsigned SLOW_HZ = 33_000;
  // Bus clock cycles per low-speed tick; a longest period rounds down.
  localparam int unsigned SLOW_DIV = PCLK_HZ / SLOW_HZ;
  localparam int unsigned DIV_W = 12;
  localparam int unsigned CNT_W = 17;
  localparam int unsigned ADDR_W = 18;

  // Register map: the key register index is a word index, shifted into a word-aligned address.
  localparam logic [15:0] KEY_IDX = 16'hff99;
  localparam logic [ADDR_W-1:0] KEY_ADDR = {KEY_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 18'h00000;
  localparam logic [ADDR_W-1:0] COUNT_ADDR = 18'h00004;
  localparam logic [ADDR_W-1:0] OPT_ADDR = 18'h00008;

  // Key values and the two fixed read values of the key register.
  localparam logic [7:0] KEY_VALUE = 8'hac;
  localparam logic [7:0] KEY_RST_ON = 8'h9a;
  localparam logic [7:0] KEY_RST_OFF = 8'h1a;

  // Option image layout, as read back in the options register.
  localparam int unsigned OPT_WIN_LO = 5;
  localparam int unsigned OPT_EN = 4;
  localparam int unsigned OPT_OVF_LO = 1;
  localparam int unsigned OPT_LOCK = 0;

  // Status register bits; the cause flag sits in bit 4.
  localparam int unsigned ST_EN = 0;
  localparam int unsigned ST_FIRST = 1;
  localparam int unsigned ST_PEND = 2;
  localparam int unsigned ST_CAUSE = 4;

  // Data accesses at or above this address are never flagged.
  localparam logic [15:0] DATA_FREE_BASE = 16'hfb00;
endpackage : wwdt_pkg

// file: rtl/wwdt_top.sv
// Windowed watchdog timer with an APB register slave.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
//
// Function
// - Key ACH write clears counter, counting resumes.
// - Key reads 9AH if enabled, else 1AH.
// - Key write of other data requests reset.
// - Bit-level key access requests reset.
// - Violation while clock stopped waits for resume.
// - Key reads return fixed value, not written.
// - Enable option gates counting and access checks.
// - Overflow without valid key requests reset.
// - Later key writes in closed window reset.
// - First key write ignores the window.
// - Three option bits select overflow period.
// - Two option bits select open fraction.
// - Closed part starts each period, open ends.
// - Clear may shift overflow by two ticks.
// - Key just before overflow still prevents reset.
// - Unlocked oscillator freezes count in HALT/STOP.
// - Stopped oscillator keeps count, no clearing.
// - Counting continues during flash self-programming.
// - Fetch or data access outside area resets; data at or above FB00H is exempt.
// - Watchdog reset sets cause flag bit 4.
module wwdt_top
  import wwdt_pkg::*;
#(
  parameter int unsigned DIV = SLOW_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic bit_access,
  input wire logic count_enable_option,
  input wire logic overflow_select_bit2,
  input wire logic overflow_select_bit1,
  input wire logic overflow_select_bit0,
  input wire logic open_span_select_hi,
  input wire logic open_span_select_lo,
  input wire logic slow_osc_lock_option,
  input wire logic slow_osc_halt_bit,
  input wire logic halt_mode,
  input wire logic stop_mode,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_addr,
  input wire logic data_valid,
  input wire logic [15:0] data_addr,
  input wire logic [15:0] memory_area_limit,
  output logic wdt_reset_req,
  output logic dog_reset_cause_flag
);

  // All state of the block.
  typedef struct packed {
    logic loaded;
    logic en;
    logic lock;
    logic [2:0] ovf;
    logic [1:0] win;
    logic [DIV_W-1:0] div;
    logic [CNT_W-1:0] cnt;
    logic first_done;
    logic clr_pend;
    logic viol_pend;
    logic req;
    logic cause;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } wwdt_state_t;

  wwdt_state_t s_r;
  wwdt_state_t s_nxt;

  // Overflow period in ticks for an overflow select code.
  function automatic logic [CNT_W:0] wwdt_period(input logic [2:0] sel);
    logic [4:0] e;
    e = 5'h07;
    unique case (sel)
      3'h0: e = 5'h07;
      3'h1: e = 5'h08;
      3'h2: e = 5'h09;
      3'h3: e = 5'h0a;
      3'h4: e = 5'h0c;
      3'h5: e = 5'h0e;
      3'h6: e = 5'h0f;
      3'h7: e = 5'h11;
    endcase
    return (CNT_W+1)'(1) << e;
  endfunction : wwdt_period

  // Length of the closed part: period times (1 - open fraction).
  function automatic logic [CNT_W:0] wwdt_closed(input logic [CNT_W:0] p,
                                                 input logic [1:0] w);
    logic [CNT_W:0] q;
    q = p >> 2;
    unique case (w)
      2'h0: return q + (q << 1);
      2'h1: return q << 1;
      2'h2: return q;
      2'h3: return '0;
    endcase
  endfunction : wwdt_closed

  logic run;
  logic tick;
  logic acc;
  logic done;
  logic wr_key;
  logic bad_key;
  logic closed;
  logic ovf_hit;
  logic area_bad;
  logic [CNT_W:0] period;
  logic [CNT_W:0] closed_lim;

  // Decoded conditions. The oscillator only stops when it is not locked.
  assign run = s_r.loaded & ~(~s_r.lock & (halt_mode | stop_mode |
                                           slow_osc_halt_bit));
  assign tick = s_r.en & run & (s_r.div == DIV_W'(DIV - 1));
  assign acc = psel & penable;
  assign done = acc & s_r.pready;
  assign wr_key = done & pwrite & (paddr == KEY_ADDR);
  // A missing low lane counts as a partial access, like a bit access.
  assign bad_key = wr_key & ((pwdata[7:0] != KEY_VALUE) | bit_access |
                             ~pstrb[0]);
  assign period = wwdt_period(s_r.ovf);
  assign closed_lim = wwdt_closed(period, s_r.win);
  assign closed = s_r.first_done & ({1'b0, s_r.cnt} < closed_lim);
  assign ovf_hit = {1'b0, s_r.cnt} == period - (CNT_W+1)'(1);
  assign area_bad = (fetch_valid & (fetch_addr >= memory_area_limit)) |
                    (data_valid & (data_addr >= memory_area_limit) &
                     (data_addr < DATA_FREE_BASE));

  // Next-state logic for the whole block.
  always_comb begin
    s_nxt = s_r;
    s_nxt.req = 1'b0;
    // Options are captured once, in the first cycle after release.
    if (!s_r.loaded) begin
      s_nxt.loaded = 1'b1;
      s_nxt.en = count_enable_option;
      s_nxt.lock = slow_osc_lock_option;
      s_nxt.ovf = {overflow_select_bit2, overflow_select_bit1,
                   overflow_select_bit0};
      s_nxt.win = {open_span_select_hi, open_span_select_lo};
    end
    // Tick divider; it freezes with the oscillator so no phase is lost.
    if (s_r.en && run) begin
      s_nxt.div = tick ? '0 : s_r.div + DIV_W'(1);
    end
    // Counter. Clears wait for a tick, as a synchroniser into the slow
    // domain would, which is where the two-tick slack comes from.
    if (tick) begin
      if (s_r.clr_pend) begin
        s_nxt.cnt = '0;
        s_nxt.clr_pend = 1'b0;
      end else if (ovf_hit) begin
        s_nxt.req = 1'b1;
        s_nxt.cnt = '0;
      end else begin
        s_nxt.cnt = s_r.cnt + CNT_W'(1);
      end
    end
    // A held violation fires only while the source clock runs.
    if (s_r.viol_pend && run) begin
      s_nxt.req = 1'b1;
      s_nxt.viol_pend = 1'b0;
    end
    // On a request the count, pending clear and first-key flag return to their reset values.
    if (s_nxt.req) begin
      s_nxt.cnt = '0;
      s_nxt.clr_pend = 1'b0;
      s_nxt.first_done = 1'b0;
    end
    // APB: one wait state, read data and error prepared with pready.
    s_nxt.pready = acc & ~s_r.pready;
    if (acc && !s_r.pready) begin
      s_nxt.prdata = '0;
      s_nxt.pslverr = 1'b0;
      unique case (paddr)
        KEY_ADDR: begin
          s_nxt.prdata[7:0] = s_r.en ? KEY_RST_ON : KEY_RST_OFF;
        end
        STATUS_ADDR: begin
          s_nxt.prdata[ST_EN] = s_r.en;
          s_nxt.prdata[ST_FIRST] = s_r.first_done;
          s_nxt.prdata[ST_PEND] = s_r.viol_pend;
          s_nxt.prdata[ST_CAUSE] = s_r.cause;
        end
        COUNT_ADDR: begin
          s_nxt.prdata[CNT_W-1:0] = s_r.cnt;
        end
        OPT_ADDR: begin
          s_nxt.prdata[OPT_WIN_LO+1:OPT_WIN_LO] = s_r.win;
          s_nxt.prdata[OPT_EN] = s_r.en;
          s_nxt.prdata[OPT_OVF_LO+2:OPT_OVF_LO] = s_r.ovf;
          s_nxt.prdata[OPT_LOCK] = s_r.lock;
        end
        default: begin
          s_nxt.pslverr = 1'b1;
        end
      endcase
    end
    // Cause flag: write one to clear; a new request wins.
    if (done && pwrite && paddr == STATUS_ADDR && pwdata[ST_CAUSE]) begin
      s_nxt.cause = 1'b0;
    end
    if (s_nxt.req) begin
      s_nxt.cause = 1'b1;
    end
    // Key writes and access checks, only while enabled.
    if (s_r.en) begin
      if (wr_key && !bad_key && !closed) begin
        s_nxt.clr_pend = 1'b1;
        s_nxt.first_done = 1'b1;
      end
      // Placed last so a new violation beats the pending clear above.
      if (bad_key || (wr_key && closed) || area_bad) begin
        s_nxt.viol_pend = 1'b1;
        s_nxt.clr_pend = 1'b0;
      end
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs come straight from the state register.
  assign pready = s_r.pready;
  assign prdata = s_r.prdata;
  assign pslverr = s_r.pslverr;
  assign wdt_reset_req = s_r.req;
  assign dog_reset_cause_flag = s_r.cause;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  key_clear_a: assert property (
    tick && s_r.clr_pend && !s_r.viol_pend |=> s_r.cnt == '0 && !s_r.req)
    else $error("key clear did not zero the counter");

  key_read_a: assert property (
    s_r.pready && acc && !pwrite && paddr == KEY_ADDR |->
    prdata[7:0] == (s_r.en ? 8'h9a : 8'h1a) && prdata[31:8] == '0)
    else $error("key register read value wrong");

  bad_data_a: assert property (
    s_r.en && wr_key && pwdata[7:0] != KEY_VALUE |=> s_r.viol_pend)
    else $error("wrong key data not flagged");

  bit_key_a: assert property (
    s_r.en && wr_key && bit_access |=> s_r.viol_pend)
    else $error("bit access to key not flagged");

  pend_hold_a: assert property (
    s_r.viol_pend && !run |=> s_r.viol_pend && !s_r.req)
    else $error("pending violation lost while clock stopped");

  pend_fire_a: assert property (
    s_r.viol_pend && run |=> s_r.req ##1 !s_r.req)
    else $error("pending violation not issued as a pulse");

  off_idle_a: assert property (
    s_r.loaded && !s_r.en |-> s_r.cnt == '0 && !s_r.req && !s_r.viol_pend)
    else $error("disabled watchdog is active");

  overflow_a: assert property (
    tick && !s_r.clr_pend && ovf_hit && !s_r.viol_pend |=> s_r.req)
    else $error("overflow did not request reset");

  closed_win_a: assert property (
    s_r.en && wr_key && !bad_key && s_r.first_done &&
    {1'b0, s_r.cnt} < closed_lim |=> s_r.viol_pend && !s_r.clr_pend)
    else $error("closed window write not flagged");

  first_key_a: assert property (
    s_r.en && wr_key && !bad_key && !s_r.first_done && !area_bad |=>
    s_r.clr_pend && s_r.first_done)
    else $error("first key write not accepted");

  late_clear_a: assert property (
    tick && s_r.clr_pend && ovf_hit && !s_r.viol_pend |=> !s_r.req)
    else $error("late key write did not prevent reset");

  freeze_a: assert property (
    s_r.loaded && !run |=> $stable(s_r.cnt))
    else $error("counter moved while oscillator stopped");

  cause_a: assert property (
    s_r.req |-> s_r.cause)
    else $error("reset request without cause flag");

  // Every period is a power of two of at least 128 ticks, so the last
  // count before overflow always has its seven low bits set.
  period_end_a: assert property (
    ovf_hit |-> s_r.cnt[6:0] == 7'h7f)
    else $error("overflow point is not a period end");

  // A correct key in the open part must be taken as a clear unless an illegal access comes in the same cycle.
  open_win_a: assert property (
    s_r.en && wr_key && !bad_key && !area_bad && !closed |=> s_r.clr_pend)
    else $error("open window key write not accepted");

  // Illegal fetches or data accesses must be flagged at once.
  area_flag_a: assert property (
    s_r.en && area_bad |=> s_r.viol_pend)
    else $error("illegal access not flagged");

  // Options are frozen once captured; only a reset takes new ones.
  opt_hold_a: assert property (
    s_r.loaded |=> $stable({s_r.en, s_r.lock, s_r.ovf, s_r.win}))
    else $error("option image changed after capture");

  cover_clear_c: cover property (tick && s_r.clr_pend);
  cover_ovf_c: cover property (tick && ovf_hit && !s_r.clr_pend);
  cover_window_c: cover property (s_r.en && wr_key && closed);
  cover_resume_c: cover property (s_r.viol_pend && !run ##1 run);
  cover_area_c: cover property (s_r.en && area_bad);

endmodule : wwdt_top

// file: bench/wwdt_cpu_model.sv
// CPU core model that reads and writes the watchdog registers with byte strobes.
`timescale 1ns/100ps
module wwdt_cpu_model
  import wwdt_pkg::*;
(
  input wire logic pclk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  output logic bit_access
);
  // The bus is idle at time zero.
  initial begin
    {psel, penable, pwrite, bit_access} = 4'h0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'h0;
  end

  // One transfer: a setup cycle, then the access is held until pready is
  // seen high at a rising edge, where read data and error are taken too.
  // The wait has no limit of its own; only the bench watchdog ends it.
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
      input logic [31:0] d, input logic [3:0] s, input logic b,
      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    bit_access <= b & wr;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable, bit_access} <= 3'h0;
    pwdata <= ~d;
  endtask : xfer
endmodule : wwdt_cpu_model

// file: bench/windowed_watchdog_timer_tb_top.sv
// Self-checking testbench for the windowed watchdog timer.
`timescale 1ns/100ps
module windowed_watchdog_timer_tb_top;
  import wwdt_pkg::*;
  localparam int D = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, bit_access, req, cause, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, c;
  logic [3:0] pstrb;
  logic [6:0] opt = 7'h71;
  logic halt = 1'b0, stop = 1'b0, osc_off = 1'b0, fv = 1'b0, dv = 1'b0;
  logic [15:0] fa = 16'h0000, da = 16'h0000, lim = 16'h8000;
  int mismatches = 0, num_checks = 0, reqs = 0, base = 0;

  // Free-running bus clock and a tally of reset requests.
  always #4 pclk = ~pclk;
  always @(posedge pclk) if (req === 1'b1) reqs <= reqs + 1;

  wwdt_top #(.DIV(D)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .bit_access(bit_access), .count_enable_option(opt[4]),
    .overflow_select_bit2(opt[3]), .overflow_select_bit1(opt[2]),
    .overflow_select_bit0(opt[1]), .open_span_select_hi(opt[6]),
    .open_span_select_lo(opt[5]), .slow_osc_lock_option(opt[0]),
    .slow_osc_halt_bit(osc_off), .halt_mode(halt), .stop_mode(stop),
    .fetch_valid(fv), .fetch_addr(fa), .data_valid(dv), .data_addr(da),
    .memory_area_limit(lim), .wdt_reset_req(req),
    .dog_reset_cause_flag(cause));

  wwdt_cpu_model cpu_u (.pclk(pclk), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .bit_access(bit_access));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  // Options are only taken at reset release, so each setup resets.
  task automatic restart(input logic [6:0] o);
    @(posedge pclk);
    presetn <= 1'b0;
    opt <= o;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    base = reqs;
  endtask : restart

  task automatic put(input logic [ADDR_W-1:0] a, input logic [31:0] d,
      input logic [3:0] s, input logic b);
    cpu_u.xfer(1'b1, a, d, s, b, rd, err);
  endtask : put

  task automatic get(input logic [ADDR_W-1:0] a);
    cpu_u.xfer(1'b0, a, 32'h0, 4'h0, 1'b0, rd, err);
  endtask : get

  task automatic after(input int n, input int w);
    repeat (w) @(posedge pclk);
    @(negedge pclk);
    check(reqs - base, n);
  endtask : after

  task automatic t_regs;
    restart(7'h71);
    get(KEY_ADDR);
    check(rd, 32'h9a);
    get(OPT_ADDR);
    check(rd, 32'h71);
    get(18'h0000c);
    check(err, 1'b1);
    put(KEY_ADDR, 32'hac, 4'hf, 1'b0);
    get(KEY_ADDR);
    check(rd, 32'h9a);
    restart(7'h61);
    get(KEY_ADDR);
    check(rd, 32'h1a);
    put(KEY_ADDR, 32'h55, 4'hf, 1'b0);
    fv <= 1'b1;
    fa <= 16'hf000;
    @(posedge pclk);
    fv <= 1'b0;
    after(0, 8 * D);
    get(COUNT_ADDR);
    check(rd, 32'h0);
    $display("test regs done");
  endtask : t_regs

  // Overflow after 2^N ticks, from two ticks early to three ticks late.
  task automatic t_overflow;
    int n;
    int p;
    for (int i = 0; i < 5; i++) begin
      p = (i < 4) ? (128 << i) : 4096;
      // The window stays fully open, so the barred pairing never occurs.
      restart({3'h7, i[2:0], 1'b1});
      n = 0;
      while (reqs == base && n < 20000) begin
        @(negedge pclk);
        n++;
      end
      check(n >= (p - 2) * D && n <= (p + 3) * D, 1'b1);
    end
    get(STATUS_ADDR);
    check(rd[ST_CAUSE], 1'b1);
    check(cause, 1'b1);
    put(STATUS_ADDR, 32'h10, 4'hf, 1'b0);
    get(STATUS_ADDR);
    check(rd[ST_CAUSE], 1'b0);
    check(cause, 1'b0);
    restart(7'h71);
    repeat (125 * D) @(posedge pclk);
    put(KEY_ADDR, 32'hac, 4'hf, 1'b0);
    after(0, 20);
    $display("test overflow done");
  endtask : t_overflow

  // 25% open window on a 256-tick period.
  task automatic t_window;
    restart(7'h13);
    repeat (100) @(posedge pclk);
    put(KEY_ADDR, 32'hac, 4'hf, 1'b0);
    after(0, 4);
    get(COUNT_ADDR);
    check(rd < 2, 1'b1);
    repeat (200 * D) @(posedge pclk);
    put(KEY_ADDR, 32'hac, 4'hf, 1'b0);
    after(0, 4);
    put(KEY_ADDR, 32'hac, 4'hf, 1'b0);
    after(1, 4);
    $display("test window done");
  endtask : t_window

  task automatic t_faults;
    restart(7'h71);
    put(KEY_ADDR, 32'h55, 4'hf, 1'b0);
    after(1, 4);
    restart(7'h71);
    put(KEY_ADDR, 32'hac, 4'hf, 1'b1);
    after(1, 4);
    restart(7'h71);
    da <= 16'hfc00;
    dv <= 1'b1;
    @(posedge pclk);
    da <= 16'h8100;
    @(posedge pclk);
    dv <= 1'b0;
    after(1, 4);
    fa <= 16'h9000;
    fv <= 1'b1;
    @(posedge pclk);
    fv <= 1'b0;
    after(2, 4);
    $display("test faults done");
  endtask : t_faults

  // Each stop source freezes the count and delays a violation.
  task automatic t_stop;
    for (int j = 0; j < 3; j++) begin
      restart(7'h70);
      repeat (20 * D) @(posedge pclk);
      {osc_off, stop, halt} <= 3'h1 << j;
      get(COUNT_ADDR);
      c = rd;
      repeat (10 * D) @(posedge pclk);
      get(COUNT_ADDR);
      check(rd, c);
      put(KEY_ADDR, 32'h55, 4'hf, 1'b0);
      after(0, 8);
      {osc_off, stop, halt} <= 3'h0;
      after(1, 6);
    end
    $display("test stop done");
  endtask : t_stop

  // Main sequence.
  initial begin
    t_regs();
    t_overflow();
    t_window();
    t_faults();
    t_stop();
    conclude();
  end

  // Cuts a hang short well after the expected run length.
  initial begin
    repeat (90000) @(posedge pclk);
    mismatches++;
    conclude();
  end
endmodule : windowed_watchdog_timer_tb_top
